// file: hdl/otgr_pkg.sv
// ----------------------------------------------------------------------------
// shared constants for the otg register bank
// ----------------------------------------------------------------------------
package otgr_pkg;

  // register indices on the two-bit register port
  localparam logic [1:0] OTGR_IDX_FLAGS = 2'h0;   // event flags, write 1 to clear
  localparam logic [1:0] OTGR_IDX_ENABLE = 2'h1;  // otg_event_enable
  localparam logic [1:0] OTGR_IDX_STATUS = 2'h2;  // otg_line_status
  localparam logic [1:0] OTGR_IDX_CONTROL = 2'h3; // otg_pull_vbus_control

  // event and enable bit positions (flags share the same layout)
  localparam int OTGR_EV_ID = 7;
  localparam int OTGR_EV_MS = 6;
  localparam int OTGR_EV_LINE = 5;
  localparam int OTGR_EV_ACT = 4;
  localparam int OTGR_EV_SESS = 3;
  localparam int OTGR_EV_BEND = 2;
  localparam int OTGR_EV_AVBUS = 0;
  localparam logic [7:0] OTGR_EV_MASK = 8'hFD;    // bit 1 not implemented

  // status bit positions
  localparam int OTGR_ST_ID = 7;
  localparam int OTGR_ST_STEADY = 5;
  localparam int OTGR_ST_SESS = 3;
  localparam int OTGR_ST_BEND = 2;
  localparam int OTGR_ST_AVBUS = 0;

  // control bit positions
  localparam int OTGR_CT_DP_UP = 7;
  localparam int OTGR_CT_DM_UP = 6;
  localparam int OTGR_CT_DP_DN = 5;
  localparam int OTGR_CT_DM_DN = 4;
  localparam int OTGR_CT_VBUS_ON = 3;
  localparam int OTGR_CT_SW_OVR = 2;
  localparam int OTGR_CT_CHARGE = 1;
  localparam int OTGR_CT_BLEED = 0;

  // reset values
  localparam logic [7:0] OTGR_RST_BYTE = 8'h00;
  localparam logic [31:0] OTGR_RST_WORD = 32'h0000_0000;

  // timing: one millisecond at the core clock
  localparam int OTGR_CLK_PERIOD_PS = 4000;
  localparam int OTGR_MS_TIME_PS = 1000000000;
  localparam int OTGR_MS_CYCLES = OTGR_MS_TIME_PS / OTGR_CLK_PERIOD_PS;

  typedef logic [7:0] otgr_byte_type;

endpackage

// file: hdl/otgr_line_if.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// line watcher results handed to the register bank
// ----------------------------------------------------------------------------
interface otgr_line_if;
  logic ms_tick;      // one-cycle pulse every millisecond
  logic line_steady;  // line state unchanged for the last millisecond
  logic steady_event; // pulse: newly steady in a state unlike the last one
  modport watch (output ms_tick, output line_steady, output steady_event);
  modport regs (input ms_tick, input line_steady, input steady_event);
endinterface

// file: hdl/otgr_line_watch.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// millisecond timer and line stability watcher
// ----------------------------------------------------------------------------
module otgr_line_watch
  import otgr_pkg::*;
#(
  parameter int MS_CYCLES = OTGR_MS_CYCLES,
  parameter int CNT_W = $clog2(MS_CYCLES + 1)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic se0,
  input wire logic line_j_indication,
  otgr_line_if.watch line
);

  logic [CNT_W-1:0] tick_cnt_q;   // free running millisecond divider
  logic [CNT_W-1:0] stab_cnt_q;   // cycles since last line change
  logic [1:0] line_prev_q;        // line state one cycle ago
  logic [1:0] last_steady_q;      // state at the last steady report
  logic steady_q;
  logic tick_q;
  logic event_q;
  wire [1:0] line_now = {se0, line_j_indication};
  wire line_moved = line_now != line_prev_q;
  wire tick_end = tick_cnt_q == CNT_W'(MS_CYCLES - 1);
  wire stab_end = stab_cnt_q == CNT_W'(MS_CYCLES - 1);
  // steady is reached on the cycle a full millisecond passes without change
  wire becomes_steady = stab_end && !line_moved && !steady_q;

  // ----------------------------------------------------------------------------
  // millisecond divider
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_end ? '0 : tick_cnt_q + 1'b1;
      tick_q <= tick_end;
    end
  end

  // ----------------------------------------------------------------------------
  // stability counter
  // ----------------------------------------------------------------------------
  // restart on change
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stab_cnt_q <= '0;
      line_prev_q <= 2'h0;
      steady_q <= 1'b0;
    end else begin
      line_prev_q <= line_now;
      // any change drops steady at the next edge, so stale stability shows for the one cycle of the change
      if (line_moved) begin
        stab_cnt_q <= '0;
        steady_q <= 1'b0;
      end else if (!stab_end) begin
        stab_cnt_q <= stab_cnt_q + 1'b1;
      end else begin
        steady_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // new steady state event
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_steady_q <= 2'h0;
      event_q <= 1'b0;
    end else begin
      event_q <= becomes_steady && (line_now != last_steady_q);
      if (becomes_steady) begin
        last_steady_q <= line_now;
      end
    end
  end

  assign line.ms_tick = tick_q;
  assign line.line_steady = steady_q;
  assign line.steady_event = event_q;

endmodule

// file: hdl/otgr_regs.sv
`timescale 1ns/10ps
module otgr_regs
  import otgr_pkg::*;
#(
  parameter int MS_CYCLES = OTGR_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] reg_idx,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // cable, transceiver and comparators
  input wire logic cable_id,
  input wire logic se0,
  input wire logic line_j_indication,
  input wire logic dplus_rx,
  input wire logic dminus_rx,
  input wire logic session_ok_cmp,
  input wire logic b_session_over_cmp,
  input wire logic a_vbus_ok_cmp,
  // pull requests from the usb core
  input wire logic [3:0] hw_pull_req,
  // resistor and supply controls
  output logic dplus_pullup_en,
  output logic dminus_pullup_en,
  output logic dplus_pulldown_en,
  output logic dminus_pulldown_en,
  output logic vbus_supply_drive,
  output logic vbus_charge_en,
  output logic vbus_bleed_en,
  output logic otg_irq
);

  // ----------------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------------
  otgr_byte_type enable_q;   // event enables
  otgr_byte_type flags_q;    // sticky event flags
  otgr_byte_type control_q;  // pull and vbus controls
  otgr_byte_type status_q;   // sampled live status
  otgr_byte_type pins_q;     // previous pin levels for change detection
  logic [3:0] pull_q;        // resistor enables actually applied
  logic primed_q;            // low for the first cycle after reset
  logic irq_q;
  logic [31:0] rdata_q;

  // the line watcher owns the millisecond timer and the stability count
  otgr_line_if line ();

  otgr_line_watch #(
    .MS_CYCLES(MS_CYCLES)
  ) u_watch (
    .core_clk(core_clk),
    .rst(rst),
    .se0(se0),
    .line_j_indication(line_j_indication),
    .line(line)
  );

  // ----------------------------------------------------------------------------
  // decode and event sources
  // ----------------------------------------------------------------------------
  // only the low byte lane carries register bits; the upper 24 are dropped on purpose
  function automatic otgr_byte_type pick_byte(input logic [31:0] word);
    pick_byte = word[7:0];
  endfunction

  // write strobes per register; status has none, so writes to it fall away
  wire wr_enable = reg_wr && (reg_idx == OTGR_IDX_ENABLE);
  wire wr_flags = reg_wr && (reg_idx == OTGR_IDX_FLAGS);
  wire wr_control = reg_wr && (reg_idx == OTGR_IDX_CONTROL);
  wire [7:0] pins_now = {cable_id, dplus_rx, dminus_rx, session_ok_cmp, b_session_over_cmp, a_vbus_ok_cmp, 2'h0};
  // the two low bits of the pin image are padding and never differ
  // nothing counts as a change until the history holds real pin levels
  wire [7:0] pins_diff = primed_q ? (pins_now ^ pins_q) : 8'h00;
  // activity is any movement on the data lines, id or vbus comparators
  wire act_seen = |pins_diff;

  // status image; unused positions stay zero
  // comparators count as synchronous, so no extra flops sit in front
  otgr_byte_type status_d;
  always_comb begin
    status_d = OTGR_RST_BYTE;
    status_d[OTGR_ST_ID] = cable_id;
    status_d[OTGR_ST_STEADY] = line.line_steady;
    status_d[OTGR_ST_SESS] = session_ok_cmp;
    status_d[OTGR_ST_BEND] = b_session_over_cmp;
    status_d[OTGR_ST_AVBUS] = a_vbus_ok_cmp;
  end

  // one-cycle event pulses in flag bit order
  // change events fire on both edges of each input
  otgr_byte_type events;
  always_comb begin
    events = OTGR_RST_BYTE;
    events[OTGR_EV_ID] = pins_diff[7];
    events[OTGR_EV_MS] = line.ms_tick;
    events[OTGR_EV_LINE] = line.steady_event;
    events[OTGR_EV_ACT] = act_seen;
    events[OTGR_EV_SESS] = pins_diff[4];
    events[OTGR_EV_BEND] = pins_diff[3];
    events[OTGR_EV_AVBUS] = pins_diff[2];
  end

  // clear mask stays zero unless the flag register is written
  // set wins over a same-cycle clear
  wire [7:0] clear_mask = wr_flags ? pick_byte(reg_wdata) : 8'h00;
  wire [7:0] flags_d = ((flags_q & ~clear_mask) | events) & OTGR_EV_MASK;
  // software or core owns the pulls
  wire [3:0] pull_d = control_q[OTGR_CT_SW_OVR] ? control_q[OTGR_CT_DP_UP:OTGR_CT_DM_DN] : hw_pull_req;

  // ----------------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------------
  // all cleared at reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_q <= OTGR_RST_BYTE;
      control_q <= OTGR_RST_BYTE;
      flags_q <= OTGR_RST_BYTE;
    end else begin
      // enables writable, bit 1 held zero
      if (wr_enable) begin
        enable_q <= pick_byte(reg_wdata) & OTGR_EV_MASK;
      end
      // all eight control bits are plain storage; bit 2 picks the pull owner
      // control byte
      if (wr_control) begin
        control_q <= pick_byte(reg_wdata);
      end
      // flags follow events every cycle; a write only picks what to clear
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------------------
  // pin sampling and applied outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_q <= OTGR_RST_BYTE;
      pull_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      // status is a one-cycle delayed image of the pins
      status_q <= status_d;
      // a registered mux keeps the resistor pins free of decode glitches
      // resistor enables
      pull_q <= pull_d;
      // flags_d lets the request follow a flag at the same edge
      // limitation: an enable acts one cycle after its write
      // enabled flag raises request
      irq_q <= |(flags_d & enable_q);
    end
  end

  // ----------------------------------------------------------------------------
  // change detector history
  // ----------------------------------------------------------------------------
  // the history wakes up as zero while the id pin idles high, so the first
  // cycle after reset is skipped rather than reported as a false change
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins_q <= OTGR_RST_BYTE;
      primed_q <= 1'b0;
    end else begin
      pins_q <= pins_now;
      primed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // read port, one cycle after reg_rd
  // ----------------------------------------------------------------------------
  // read data stays until the next read strobe, so software may sample late
  // a read and a write in one cycle return the old value
  // upper bits zero
  wire [7:0] rd_byte = (reg_idx == OTGR_IDX_FLAGS) ? flags_q :
                       (reg_idx == OTGR_IDX_ENABLE) ? enable_q :
                       (reg_idx == OTGR_IDX_STATUS) ? status_q : control_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= OTGR_RST_WORD;
    end else if (reg_rd) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------------------
  // vbus controls come straight from storage, with no owner switch
  assign reg_rdata = rdata_q;
  assign {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en} = pull_q;
  assign vbus_supply_drive = control_q[OTGR_CT_VBUS_ON];
  assign vbus_charge_en = control_q[OTGR_CT_CHARGE];
  assign vbus_bleed_en = control_q[OTGR_CT_BLEED];
  assign otg_irq = irq_q;

endmodule

// file: tb/otgr_regs_asserts.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// port checks for the otg register bank
// ----------------------------------------------------------------------------
module otgr_regs_asserts
  import otgr_pkg::*;
#(
  parameter int MS_CYCLES = OTGR_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] reg_idx,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic cable_id,
  input wire logic session_ok_cmp,
  input wire logic [3:0] hw_pull_req,
  input wire logic dplus_pullup_en,
  input wire logic dminus_pullup_en,
  input wire logic dplus_pulldown_en,
  input wire logic dminus_pulldown_en,
  input wire logic vbus_supply_drive,
  input wire logic vbus_charge_en,
  input wire logic vbus_bleed_en,
  input wire logic otg_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // the four resistor enables, in control bit order
  wire [3:0] pulls = {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en};
  wire ctl_wr = reg_wr && reg_idx == OTGR_IDX_CONTROL;
  sequence s_sw_owned;
    ctl_wr && reg_wdata[OTGR_CT_SW_OVR] ##1 !ctl_wr;
  endsequence
  sequence s_hw_owned;
    ctl_wr && !reg_wdata[OTGR_CT_SW_OVR] ##1 !ctl_wr;
  endsequence
  a_upper_zero: assert property (reg_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_status_gaps: assert property (reg_rd && reg_idx == OTGR_IDX_STATUS |=> (reg_rdata[6] | reg_rdata[4] | reg_rdata[1]) == 1'b0)
    else $error("unused status bit set");
  a_status_track: assert property ($stable({cable_id, session_ok_cmp})[*3] ##0 reg_rd && reg_idx == OTGR_IDX_STATUS
    |=> {reg_rdata[7], reg_rdata[3]} == $past({cable_id, session_ok_cmp}))
    else $error("status does not follow pins");
  a_vbus_direct: assert property (ctl_wr |=> {vbus_supply_drive, vbus_charge_en, vbus_bleed_en}
    == {$past(reg_wdata[3]), $past(reg_wdata[1:0])})
    else $error("vbus controls differ from written bits");
  a_irq_masked: assert property (reg_wr && reg_idx == OTGR_IDX_ENABLE && reg_wdata[7:0] == 8'h00 |-> ##2 !otg_irq)
    else $error("irq with all enables clear");
  a_hw_pulls: assert property (s_hw_owned |=> pulls == $past(hw_pull_req))
    else $error("pulls not under core control");
  a_sw_pulls: assert property (s_sw_owned |=> pulls == $past(reg_wdata[7:4], 2))
    else $error("pulls not under software control");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule
bind otgr_regs otgr_regs_asserts #(.MS_CYCLES(MS_CYCLES)) u_asserts (
  .core_clk(core_clk), .rst(rst), .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cable_id(cable_id), .session_ok_cmp(session_ok_cmp),
  .hw_pull_req(hw_pull_req), .dplus_pullup_en(dplus_pullup_en), .dminus_pullup_en(dminus_pullup_en),
  .dplus_pulldown_en(dplus_pulldown_en), .dminus_pulldown_en(dminus_pulldown_en),
  .vbus_supply_drive(vbus_supply_drive), .vbus_charge_en(vbus_charge_en), .vbus_bleed_en(vbus_bleed_en),
  .otg_irq(otg_irq));

// file: tb/otgr_cable_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// cable, transceiver and vbus comparators
// ----------------------------------------------------------------------------
module otgr_cable_model (
  input wire logic a_plug,
  input wire logic vbus_up,
  input wire logic [1:0] line_state,
  output logic cable_id,
  output logic se0,
  output logic line_j_indication,
  output logic dplus_rx,
  output logic dminus_rx,
  output logic session_ok_cmp,
  output logic b_session_over_cmp,
  output logic a_vbus_ok_cmp
);
  // id pin is pulled high unless an a plug grounds it
  assign cable_id = !a_plug;
  assign {se0, line_j_indication} = line_state;
  // se0 gives both lines low, j is d+ high, else k
  assign dplus_rx = !line_state[1] && line_state[0];
  assign dminus_rx = !line_state[1] && !line_state[0];
  assign session_ok_cmp = vbus_up;
  assign b_session_over_cmp = !vbus_up;
  assign a_vbus_ok_cmp = vbus_up && a_plug;
endmodule

// file: tb/test_otgr_regs.sv
`timescale 1ns/10ps
module test_otgr_regs
  import otgr_pkg::*;
;
  localparam int MS = 20; // short millisecond keeps the run brief
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] NO5 = 32'hFFFF_FFDF; // skip line steady bit
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_idx = 2'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, v;
  logic a_plug = 1'b0;
  logic vbus_up = 1'b0;
  logic [1:0] line_state = 2'h0;
  logic [3:0] hw_pull_req = 4'h0;
  wire cid, se0, lj, dp, dm, sok, bov, aok, otg_irq;
  wire [7:0] ctl_out;
  int num_errors = 0;
  int cmp_count = 0;
  assign ctl_out[2] = 1'b0;
  always #2 core_clk = ~core_clk;
  otgr_cable_model i_cable (.a_plug(a_plug), .vbus_up(vbus_up), .line_state(line_state), .cable_id(cid),
    .se0(se0), .line_j_indication(lj), .dplus_rx(dp), .dminus_rx(dm), .session_ok_cmp(sok),
    .b_session_over_cmp(bov), .a_vbus_ok_cmp(aok));
  otgr_regs #(.MS_CYCLES(MS)) i_dut (.core_clk(core_clk), .rst(rst), .reg_idx(reg_idx), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cable_id(cid), .se0(se0),
    .line_j_indication(lj), .dplus_rx(dp), .dminus_rx(dm), .session_ok_cmp(sok), .b_session_over_cmp(bov),
    .a_vbus_ok_cmp(aok), .hw_pull_req(hw_pull_req), .dplus_pullup_en(ctl_out[7]), .dminus_pullup_en(ctl_out[6]),
    .dplus_pulldown_en(ctl_out[5]), .dminus_pulldown_en(ctl_out[4]), .vbus_supply_drive(ctl_out[3]),
    .vbus_charge_en(ctl_out[1]), .vbus_bleed_en(ctl_out[0]), .otg_irq(otg_irq));
  // one register access per call, strobe held over one rising edge
  task automatic acc(input logic w, input logic [1:0] idx, input logic [31:0] d);
    @(negedge core_clk);
    reg_idx = idx;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdchk(input logic [1:0] idx, input logic [31:0] m, input logic [31:0] exp, input string nm);
    acc(1'b0, idx, reg_wdata);
    chk(nm, exp, reg_rdata & m);
  endtask
  // expected status from what the model is told to present
  function automatic logic [31:0] st_exp(input logic stdy);
    return {24'h00_0000, ~a_plug, 1'b0, stdy, 1'b0, vbus_up, ~vbus_up, 1'b0, vbus_up & a_plug};
  endfunction
  task automatic t_regs;
    rdchk(OTGR_IDX_ENABLE, ALL, 32'h0000_0000, "enable reset");
    rdchk(OTGR_IDX_CONTROL, ALL, 32'h0000_0000, "control reset");
    chk("pins reset", 32'h0000_0000, {24'h00_0000, ctl_out});
    acc(1'b1, OTGR_IDX_ENABLE, ALL);
    rdchk(OTGR_IDX_ENABLE, ALL, 32'h0000_00FD, "enable all");
    acc(1'b1, OTGR_IDX_ENABLE, 32'hFFFF_FF00);
    rdchk(OTGR_IDX_ENABLE, ALL, 32'h0000_0000, "enable none");
    acc(1'b1, OTGR_IDX_STATUS, ALL);
    rdchk(OTGR_IDX_STATUS, NO5, st_exp(1'b0), "status ro");
    hw_pull_req = 4'hA;
    for (int i = 0; i < 8; i++) begin
      v = 32'h0000_0004 | (32'h0000_0001 << i);
      acc(1'b1, OTGR_IDX_CONTROL, v);
      @(negedge core_clk);
      chk("control pins", v & 32'h0000_00FB, {24'h00_0000, ctl_out});
      rdchk(OTGR_IDX_CONTROL, ALL, v, "control");
    end
    acc(1'b1, OTGR_IDX_CONTROL, 32'h0000_0000);
    @(negedge core_clk);
    chk("core pulls", 32'h0000_00A0, {24'h00_0000, ctl_out});
    $display("register test done");
  endtask
  task automatic t_status;
    a_plug = 1'b1;
    vbus_up = 1'b1;
    repeat (3) @(negedge core_clk);
    rdchk(OTGR_IDX_STATUS, NO5, st_exp(1'b0), "a device");
    a_plug = 1'b0;
    repeat (3) @(negedge core_clk);
    rdchk(OTGR_IDX_STATUS, NO5, st_exp(1'b0), "b device");
    vbus_up = 1'b0;
    line_state = 2'h1;
    repeat (MS - 6) @(negedge core_clk);
    rdchk(OTGR_IDX_STATUS, ALL, st_exp(1'b0), "line young");
    repeat (MS) @(negedge core_clk);
    rdchk(OTGR_IDX_STATUS, ALL, st_exp(1'b1), "line steady");
    $display("status test done");
  endtask
  task automatic t_flags;
    acc(1'b1, OTGR_IDX_FLAGS, ALL);
    acc(1'b1, OTGR_IDX_ENABLE, 32'h0000_0080);
    a_plug = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("irq id", 32'h0000_0001, {31'h0, otg_irq});
    rdchk(OTGR_IDX_FLAGS, 32'h0000_00BF, 32'h0000_0090, "id flags");
    acc(1'b1, OTGR_IDX_FLAGS, 32'h0000_0010);
    acc(1'b1, OTGR_IDX_FLAGS, 32'h0000_0000);
    rdchk(OTGR_IDX_FLAGS, 32'h0000_00BF, 32'h0000_0080, "partial clear");
    acc(1'b1, OTGR_IDX_FLAGS, 32'h0000_0080);
    @(negedge core_clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, otg_irq});
    acc(1'b1, OTGR_IDX_ENABLE, 32'h0000_0040);
    repeat (MS + 2) @(negedge core_clk);
    chk("irq tick", 32'h0000_0001, {31'h0, otg_irq});
    acc(1'b1, OTGR_IDX_ENABLE, 32'h0000_0000);
    @(negedge core_clk);
    chk("irq masked", 32'h0000_0000, {31'h0, otg_irq});
    acc(1'b1, OTGR_IDX_FLAGS, ALL);
    vbus_up = 1'b1;
    line_state = 2'h2;
    repeat (MS + 4) @(negedge core_clk);
    rdchk(OTGR_IDX_FLAGS, 32'h0000_002D, 32'h0000_002D, "vbus line flags");
    $display("flag test done");
  endtask
  // mid-run reset with pins away from their reset image
  task automatic t_reset;
    acc(1'b1, OTGR_IDX_ENABLE, ALL);
    acc(1'b1, OTGR_IDX_CONTROL, ALL);
    @(negedge core_clk);
    chk("control set", 32'h0000_00FB, {24'h00_0000, ctl_out});
    rst = 1'b1;
    @(negedge core_clk);
    chk("outputs in reset", 32'h0000_0000, {23'h00_0000, otg_irq, ctl_out});
    rst = 1'b0;
    rdchk(OTGR_IDX_ENABLE, ALL, 32'h0000_0000, "enable after reset");
    rdchk(OTGR_IDX_CONTROL, ALL, 32'h0000_0000, "control after reset");
    rdchk(OTGR_IDX_FLAGS, 32'h0000_00BF, 32'h0000_0000, "no flags after reset");
    $display("reset test done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_regs;
    t_status;
    t_flags;
    t_reset;
    finish_test;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    finish_test;
  end
endmodule
